// ==== logic/fpes_pkg.sv ====
package fpes_pkg;

	// ------------------------------------------------------------
	// Register map of the controller
	// ------------------------------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_WDATA = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0c;
	localparam logic [7:0] REG_RDATA = 8'h10;
	localparam int CTRL_OP_LSB = 0;
	localparam int CTRL_BYTE_BIT = 8;
	localparam int ST_BUSY = 0;
	localparam int ST_TMO = 1;
	localparam int ST_RB = 2;
	localparam int ST_DONE = 3;
	localparam logic [2:0] CTRL_OP_RST = 3'h0;
	localparam logic [20:0] ADDR_RST = 21'h000000;
	localparam logic [15:0] WDATA_RST = 16'h0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ------------------------------------------------------------
	// Operations that software may start
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		OP_READ = 3'h0,
		OP_PROGRAM = 3'h1,
		OP_CHIP_ERASE = 3'h2,
		OP_SECTOR_ERASE = 3'h3,
		OP_BLOCK_ERASE = 3'h4,
		OP_SUSPEND = 3'h5,
		OP_RESUME = 3'h6,
		OP_RESET = 3'h7
	} fpes_op_t;

	// ------------------------------------------------------------
	// Device command codes and unlock addresses
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_UNLOCK1 = 8'haa;
	localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
	localparam logic [7:0] CMD_PROGRAM = 8'ha0;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
	localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
	localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
	localparam logic [7:0] CMD_BLOCK_ERASE = 8'h50;
	localparam logic [7:0] CMD_SUSPEND = 8'hb0;
	localparam logic [7:0] CMD_RESUME = 8'h30;
	localparam logic [7:0] CMD_RESET = 8'hf0;
	localparam logic [19:0] UNLOCK_ADDR1 = 20'h00555;
	localparam logic [19:0] UNLOCK_ADDR2 = 20'h002aa;
	localparam logic [2:0] STEPS_PROGRAM = 3'h4;
	localparam logic [2:0] STEPS_ERASE = 3'h6;
	localparam logic [2:0] STEPS_SINGLE = 3'h1;
	localparam int DQ_POLL = 7;
	localparam int DQ_TIMEOUT = 5;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_NS = 20;
	localparam int T_SETUP_NS = 20;
	localparam int T_PULSE_NS = 70;
	localparam int T_HOLD_NS = 20;
	localparam int T_SUSPEND_US = 20;
	localparam int SETUP_CYC = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
	localparam int PULSE_CYC = (T_PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam int HOLD_CYC = (T_HOLD_NS + CLK_NS - 1) / CLK_NS;
	localparam int SUSPEND_CYC = (T_SUSPEND_US * 1000 + CLK_NS - 1) / CLK_NS;

endpackage

// ==== logic/fpes_bus_cycle.sv ====
`timescale 1ns/100ps
module fpes_bus_cycle #(
	parameter int SETUP_CYC = fpes_pkg::SETUP_CYC,
	parameter int PULSE_CYC = fpes_pkg::PULSE_CYC,
	parameter int HOLD_CYC = fpes_pkg::HOLD_CYC
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// Cycle request
	input wire logic i_start,
	input wire logic i_write,
	input wire logic i_byte_mode,
	input wire logic [19:0] i_addr,
	input wire logic i_addr_lsb,
	input wire logic [15:0] i_wdata,
	output logic o_done,
	output logic [15:0] o_rdata,
	// Flash pins
	output logic o_ce_n,
	output logic o_we_n,
	output logic o_oe_n,
	output logic [19:0] o_addr,
	output logic [15:0] o_dq,
	output logic [15:0] o_dq_oe_n,
	input wire logic [15:0] i_dq
);

	// ------------------------------------------------------------
	// Parameter check
	// ------------------------------------------------------------
	if (SETUP_CYC < 1 || PULSE_CYC < 1 || HOLD_CYC < 1
		|| SETUP_CYC > 256 || PULSE_CYC > 256 || HOLD_CYC > 256)
	begin : g_bad
		$error("Cycle timing counts out of range.");
	end

	typedef enum logic [1:0] {
		CY_IDLE = 2'b00,
		CY_SETUP = 2'b01,
		CY_PULSE = 2'b10,
		CY_HOLD = 2'b11
	} fpes_cy_t;

	fpes_cy_t state_r;
	logic [7:0] cnt_r;
	logic write_r;

	// ------------------------------------------------------------
	// Phase sequencer
	// ------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			state_r <= CY_IDLE;
			cnt_r <= 8'h00;
			write_r <= 1'b0;
			o_done <= 1'b0;
			o_rdata <= 16'h0000;
			o_ce_n <= 1'b1;
			o_we_n <= 1'b1;
			o_oe_n <= 1'b1;
			o_addr <= 20'h00000;
			o_dq <= 16'h0000;
			o_dq_oe_n <= 16'hffff;
		end
		else
		begin
			o_done <= 1'b0;
			case (state_r)
				CY_IDLE:
				begin
					if (i_start)
					begin
						// Address and data settle before either strobe falls.
						write_r <= i_write;
						o_addr <= i_addr;
						o_ce_n <= 1'b0;
						o_dq <= i_byte_mode ? {i_addr_lsb, 7'h00, i_wdata[7:0]} : i_wdata;
						o_dq_oe_n <= i_byte_mode ? {1'b0, 7'h7f, {8{~i_write}}}
							: {16{~i_write}};
						cnt_r <= 8'(SETUP_CYC - 1);
						state_r <= CY_SETUP;
					end
				end
				CY_SETUP:
				begin
					if (cnt_r == 8'h00)
					begin
						o_we_n <= ~write_r;
						o_oe_n <= write_r;
						cnt_r <= 8'(PULSE_CYC - 1);
						state_r <= CY_PULSE;
					end
					else
					begin
						cnt_r <= cnt_r - 8'h01;
					end
				end
				CY_PULSE:
				begin
					if (cnt_r == 8'h00)
					begin
						// Write enable rises first so the data is taken there.
						o_we_n <= 1'b1;
						o_oe_n <= 1'b1;
						o_rdata <= i_dq;
						cnt_r <= 8'(HOLD_CYC - 1);
						state_r <= CY_HOLD;
					end
					else
					begin
						cnt_r <= cnt_r - 8'h01;
					end
				end
				CY_HOLD:
				begin
					if (cnt_r == 8'h00)
					begin
						o_ce_n <= 1'b1;
						o_dq_oe_n <= 16'hffff;
						o_done <= 1'b1;
						state_r <= CY_IDLE;
					end
					else
					begin
						cnt_r <= cnt_r - 8'h01;
					end
				end
				default:
				begin
					state_r <= CY_IDLE;
				end
			endcase
		end
	end

endmodule

// ==== logic/fpes_ctrl.sv ====
//
// Contract
// - Program is two unlocks, setup command, then address and data.
// - Timeout bit goes high on overrun; a reset command restores read mode.
// - Chip erase is two unlocks, setup, two unlocks, chip erase command.
// - Sector or block erase is six writes, last carries target and command.
// - Resume continues erase; repeats ignored; later suspend accepted again.
// - Polling must address the sector being programmed or erased.
// - Polling bit may flip early; confirm the data with a further read.
//
// Design decisions made here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/100ps
module fpes_ctrl #(
	parameter int SUSPEND_WAIT_CYC = fpes_pkg::SUSPEND_CYC
) (
	// Clock and reset
	input wire logic I_CLK_SYS,
	input wire logic I_RESET_N,
	// AXI4-Lite write channels
	input wire logic [7:0] I_AXI_AWADDR,
	input wire logic I_AXI_AWVALID,
	output logic O_AXI_AWREADY,
	input wire logic [31:0] I_AXI_WDATA,
	input wire logic [3:0] I_AXI_WSTRB,
	input wire logic I_AXI_WVALID,
	output logic O_AXI_WREADY,
	output logic [1:0] O_AXI_BRESP,
	output logic O_AXI_BVALID,
	input wire logic I_AXI_BREADY,
	// AXI4-Lite read channels
	input wire logic [7:0] I_AXI_ARADDR,
	input wire logic I_AXI_ARVALID,
	output logic O_AXI_ARREADY,
	output logic [31:0] O_AXI_RDATA,
	output logic [1:0] O_AXI_RRESP,
	output logic O_AXI_RVALID,
	input wire logic I_AXI_RREADY,
	// Flash pins
	output logic O_FLASH_CE_N,
	output logic O_FLASH_WE_N,
	output logic O_FLASH_OE_N,
	output logic O_FLASH_BYTE_N,
	output logic [19:0] O_FLASH_ADDR,
	output logic [15:0] O_FLASH_DQ,
	output logic [15:0] O_FLASH_DQ_OE_N,
	input wire logic [15:0] I_FLASH_DQ,
	input wire logic I_FLASH_READY_BUSY_N
);

	if (SUSPEND_WAIT_CYC < 1 || SUSPEND_WAIT_CYC > 65535)
	begin : g_bad
		$error("Suspend wait count out of range.");
	end

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_WR = 3'b001,
		ST_WR_WAIT = 3'b010,
		ST_RD = 3'b011,
		ST_RD_WAIT = 3'b100,
		ST_SUSP = 3'b101
	} fpes_st_t;

	fpes_st_t state_r;
	fpes_pkg::fpes_op_t op_r;
	logic [2:0] step_r;
	logic [2:0] nsteps_r;
	logic confirm_r;
	logic recheck_r;
	logic [15:0] susp_cnt_r;
	logic busy_r;
	logic done_r;
	logic tmo_r;
	logic rb_r;
	logic byte_mode_r;
	logic [20:0] addr_r;
	logic [15:0] wdata_r;
	logic [15:0] rdata_r;
	logic start_r;
	logic [2:0] start_op_r;
	logic cyc_start;
	logic cyc_write;
	logic cyc_done;
	logic [15:0] cyc_rdata;
	logic [19:0] cyc_addr;
	logic cyc_lsb;
	logic [15:0] cyc_wdata;
	logic [19:0] tgt_addr;
	logic tgt_lsb;
	logic poll_match;

	// ------------------------------------------------------------
	// AXI4-Lite slave
	// ------------------------------------------------------------
	logic aw_held_r;
	logic w_held_r;
	logic [7:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic aw_fire;
	logic w_fire;
	logic ar_fire;
	logic wr_do;
	logic aw_held_nxt;
	logic w_held_nxt;
	logic bvalid_nxt;
	logic rvalid_nxt;
	logic [31:0] wmerged;
	logic [31:0] rd_word;
	logic rd_hit;

	assign aw_fire = I_AXI_AWVALID & O_AXI_AWREADY;
	assign w_fire = I_AXI_WVALID & O_AXI_WREADY;
	assign ar_fire = I_AXI_ARVALID & O_AXI_ARREADY;
	assign wr_do = aw_held_r & w_held_r & ~O_AXI_BVALID;
	assign aw_held_nxt = (aw_held_r | aw_fire) & ~wr_do;
	assign w_held_nxt = (w_held_r | w_fire) & ~wr_do;
	assign bvalid_nxt = wr_do | (O_AXI_BVALID & ~I_AXI_BREADY);
	assign rvalid_nxt = ar_fire | (O_AXI_RVALID & ~I_AXI_RREADY);

	always_comb
	begin
		for (int i = 0; i < 4; i++)
		begin
			wmerged[i*8 +: 8] = w_strb_r[i] ? w_data_r[i*8 +: 8] : 8'h00;
		end
		rd_hit = 1'b1;
		case (I_AXI_ARADDR)
			fpes_pkg::REG_CTRL: rd_word = {23'h000000, byte_mode_r, 5'h00, op_r};
			fpes_pkg::REG_ADDR: rd_word = {11'h000, addr_r};
			fpes_pkg::REG_WDATA: rd_word = {16'h0000, wdata_r};
			fpes_pkg::REG_STATUS: rd_word = {28'h0000000, done_r, rb_r, tmo_r, busy_r};
			fpes_pkg::REG_RDATA: rd_word = {16'h0000, rdata_r};
			default:
			begin
				rd_word = 32'h00000000;
				rd_hit = 1'b0;
			end
		endcase
	end

	always_ff @(posedge I_CLK_SYS or negedge I_RESET_N)
	begin
		if (!I_RESET_N)
		begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_data_r <= 32'h00000000;
			w_strb_r <= 4'h0;
			O_AXI_AWREADY <= 1'b0;
			O_AXI_WREADY <= 1'b0;
			O_AXI_BVALID <= 1'b0;
			O_AXI_BRESP <= fpes_pkg::RESP_OKAY;
		end
		else
		begin
			aw_held_r <= aw_held_nxt;
			w_held_r <= w_held_nxt;
			if (aw_fire)
			begin
				aw_addr_r <= I_AXI_AWADDR;
			end
			if (w_fire)
			begin
				w_data_r <= I_AXI_WDATA;
				w_strb_r <= I_AXI_WSTRB;
			end
			O_AXI_AWREADY <= ~aw_held_nxt & ~bvalid_nxt;
			O_AXI_WREADY <= ~w_held_nxt & ~bvalid_nxt;
			O_AXI_BVALID <= bvalid_nxt;
			if (wr_do)
			begin
				case (aw_addr_r)
					fpes_pkg::REG_CTRL, fpes_pkg::REG_ADDR, fpes_pkg::REG_WDATA,
					fpes_pkg::REG_STATUS, fpes_pkg::REG_RDATA:
						O_AXI_BRESP <= fpes_pkg::RESP_OKAY;
					default: O_AXI_BRESP <= fpes_pkg::RESP_SLVERR;
				endcase
			end
		end
	end

	always_ff @(posedge I_CLK_SYS or negedge I_RESET_N)
	begin
		if (!I_RESET_N)
		begin
			O_AXI_ARREADY <= 1'b0;
			O_AXI_RVALID <= 1'b0;
			O_AXI_RDATA <= 32'h00000000;
			O_AXI_RRESP <= fpes_pkg::RESP_OKAY;
		end
		else
		begin
			O_AXI_ARREADY <= ~rvalid_nxt;
			O_AXI_RVALID <= rvalid_nxt;
			if (ar_fire)
			begin
				O_AXI_RDATA <= rd_word;
				O_AXI_RRESP <= rd_hit ? fpes_pkg::RESP_OKAY : fpes_pkg::RESP_SLVERR;
			end
		end
	end

	// ------------------------------------------------------------
	// Software registers
	// ------------------------------------------------------------
	always_ff @(posedge I_CLK_SYS or negedge I_RESET_N)
	begin
		if (!I_RESET_N)
		begin
			byte_mode_r <= 1'b0;
			O_FLASH_BYTE_N <= 1'b1;
			addr_r <= fpes_pkg::ADDR_RST;
			wdata_r <= fpes_pkg::WDATA_RST;
			start_r <= 1'b0;
			start_op_r <= fpes_pkg::CTRL_OP_RST;
			rb_r <= 1'b1;
		end
		else
		begin
			start_r <= 1'b0;
			rb_r <= I_FLASH_READY_BUSY_N;
			if (wr_do && !busy_r && !start_r)
			begin
				case (aw_addr_r)
					fpes_pkg::REG_CTRL:
					begin
						// The byte select pin picks 8-bit or 16-bit units.
						byte_mode_r <= wmerged[fpes_pkg::CTRL_BYTE_BIT];
						O_FLASH_BYTE_N <= ~wmerged[fpes_pkg::CTRL_BYTE_BIT];
						start_op_r <= wmerged[fpes_pkg::CTRL_OP_LSB +: 3];
						start_r <= 1'b1;
					end
					fpes_pkg::REG_ADDR: addr_r <= wmerged[20:0];
					fpes_pkg::REG_WDATA: wdata_r <= wmerged[15:0];
					default:
					begin
					end
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Command step table
	// ------------------------------------------------------------
	assign tgt_addr = byte_mode_r ? addr_r[20:1] : addr_r[19:0];
	assign tgt_lsb = byte_mode_r & addr_r[0];

	always_comb
	begin
		cyc_addr = fpes_pkg::UNLOCK_ADDR1;
		cyc_lsb = 1'b0;
		cyc_wdata = {8'h00, fpes_pkg::CMD_UNLOCK1};
		if (nsteps_r == fpes_pkg::STEPS_SINGLE)
		begin
			// Suspend, resume and reset carry a don't-care address.
			case (op_r)
				fpes_pkg::OP_SUSPEND: cyc_wdata = {8'h00, fpes_pkg::CMD_SUSPEND};
				fpes_pkg::OP_RESUME: cyc_wdata = {8'h00, fpes_pkg::CMD_RESUME};
				default: cyc_wdata = {8'h00, fpes_pkg::CMD_RESET};
			endcase
		end
		else
		begin
			case (step_r)
				3'h1, 3'h4:
				begin
					cyc_addr = fpes_pkg::UNLOCK_ADDR2;
					cyc_lsb = byte_mode_r;
					cyc_wdata = {8'h00, fpes_pkg::CMD_UNLOCK2};
				end
				3'h2:
				begin
					cyc_wdata = (op_r == fpes_pkg::OP_PROGRAM) ? {8'h00, fpes_pkg::CMD_PROGRAM}
						: {8'h00, fpes_pkg::CMD_ERASE_SETUP};
				end
				3'h3:
				begin
					if (op_r == fpes_pkg::OP_PROGRAM)
					begin
						// Fourth write carries the target and its data.
						cyc_addr = tgt_addr;
						cyc_lsb = tgt_lsb;
						cyc_wdata = wdata_r;
					end
				end
				3'h5:
				begin
					// Sixth write carries the erase command.
					case (op_r)
						fpes_pkg::OP_SECTOR_ERASE:
						begin
							cyc_addr = tgt_addr;
							cyc_lsb = tgt_lsb;
							cyc_wdata = {8'h00, fpes_pkg::CMD_SECTOR_ERASE};
						end
						fpes_pkg::OP_BLOCK_ERASE:
						begin
							cyc_addr = tgt_addr;
							cyc_lsb = tgt_lsb;
							cyc_wdata = {8'h00, fpes_pkg::CMD_BLOCK_ERASE};
						end
						default: cyc_wdata = {8'h00, fpes_pkg::CMD_CHIP_ERASE};
					endcase
				end
				default:
				begin
				end
			endcase
		end
	end

	// Program expects true bit 7 back, erase expects a one.
	assign poll_match = (op_r == fpes_pkg::OP_PROGRAM)
		? (cyc_rdata[fpes_pkg::DQ_POLL] == wdata_r[fpes_pkg::DQ_POLL])
		: cyc_rdata[fpes_pkg::DQ_POLL];

	// ------------------------------------------------------------
	// Operation sequencer
	// ------------------------------------------------------------
	always_ff @(posedge I_CLK_SYS or negedge I_RESET_N)
	begin
		if (!I_RESET_N)
		begin
			state_r <= ST_IDLE;
			op_r <= fpes_pkg::OP_READ;
			step_r <= 3'h0;
			nsteps_r <= 3'h0;
			confirm_r <= 1'b0;
			recheck_r <= 1'b0;
			susp_cnt_r <= 16'h0000;
			busy_r <= 1'b0;
			done_r <= 1'b0;
			tmo_r <= 1'b0;
			rdata_r <= 16'h0000;
			cyc_start <= 1'b0;
			cyc_write <= 1'b0;
		end
		else
		begin
			cyc_start <= 1'b0;
			case (state_r)
				ST_IDLE:
				begin
					if (start_r)
					begin
						op_r <= fpes_pkg::fpes_op_t'(start_op_r);
						busy_r <= 1'b1;
						done_r <= 1'b0;
						tmo_r <= 1'b0;
						step_r <= 3'h0;
						confirm_r <= 1'b0;
						recheck_r <= 1'b0;
						case (fpes_pkg::fpes_op_t'(start_op_r))
							fpes_pkg::OP_READ:
							begin
								confirm_r <= 1'b1;
								state_r <= ST_RD;
							end
							fpes_pkg::OP_PROGRAM:
							begin
								nsteps_r <= fpes_pkg::STEPS_PROGRAM;
								state_r <= ST_WR;
							end
							fpes_pkg::OP_CHIP_ERASE, fpes_pkg::OP_SECTOR_ERASE,
							fpes_pkg::OP_BLOCK_ERASE:
							begin
								nsteps_r <= fpes_pkg::STEPS_ERASE;
								state_r <= ST_WR;
							end
							default:
							begin
								nsteps_r <= fpes_pkg::STEPS_SINGLE;
								state_r <= ST_WR;
							end
						endcase
					end
				end
				ST_WR:
				begin
					cyc_start <= 1'b1;
					cyc_write <= 1'b1;
					state_r <= ST_WR_WAIT;
				end
				ST_WR_WAIT:
				begin
					if (cyc_done)
					begin
						if (step_r != nsteps_r - 3'h1)
						begin
							step_r <= step_r + 3'h1;
							state_r <= ST_WR;
						end
						else if (nsteps_r != fpes_pkg::STEPS_SINGLE)
						begin
							// The device runs the algorithm alone; the host only polls.
							state_r <= ST_RD;
						end
						else if (op_r == fpes_pkg::OP_SUSPEND)
						begin
							susp_cnt_r <= 16'(SUSPEND_WAIT_CYC - 1);
							state_r <= ST_SUSP;
						end
						else
						begin
							busy_r <= 1'b0;
							done_r <= 1'b1;
							state_r <= ST_IDLE;
						end
					end
				end
				ST_SUSP:
				begin
					// Allow the erase to halt before reporting done.
					if (susp_cnt_r == 16'h0000)
					begin
						busy_r <= 1'b0;
						done_r <= 1'b1;
						state_r <= ST_IDLE;
					end
					else
					begin
						susp_cnt_r <= susp_cnt_r - 16'h0001;
					end
				end
				ST_RD:
				begin
					// Reads go to the target so polling stays in its sector.
					cyc_start <= 1'b1;
					cyc_write <= 1'b0;
					state_r <= ST_RD_WAIT;
				end
				ST_RD_WAIT:
				begin
					if (cyc_done)
					begin
						if (confirm_r)
						begin
							rdata_r <= cyc_rdata;
							busy_r <= 1'b0;
							done_r <= 1'b1;
							state_r <= ST_IDLE;
						end
						else if (poll_match)
						begin
							// Low bits may lag the polling bit, so read again.
							confirm_r <= 1'b1;
							state_r <= ST_RD;
						end
						else if (cyc_rdata[fpes_pkg::DQ_TIMEOUT] && recheck_r)
						begin
							// Failed operation: reset command back to read mode.
							tmo_r <= 1'b1;
							rdata_r <= cyc_rdata;
							op_r <= fpes_pkg::OP_RESET;
							nsteps_r <= fpes_pkg::STEPS_SINGLE;
							step_r <= 3'h0;
							state_r <= ST_WR;
						end
						else
						begin
							// Timeout may coincide with completion; poll once more.
							recheck_r <= cyc_rdata[fpes_pkg::DQ_TIMEOUT];
							state_r <= ST_RD;
						end
					end
				end
				default:
				begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Flash bus cycles
	// ------------------------------------------------------------
	fpes_bus_cycle u_cycle (
		.i_clk(I_CLK_SYS),
		.i_reset_n(I_RESET_N),
		.i_start(cyc_start),
		.i_write(cyc_write),
		.i_byte_mode(byte_mode_r),
		.i_addr(cyc_write ? cyc_addr : tgt_addr),
		.i_addr_lsb(cyc_write ? cyc_lsb : tgt_lsb),
		.i_wdata(cyc_wdata),
		.o_done(cyc_done),
		.o_rdata(cyc_rdata),
		.o_ce_n(O_FLASH_CE_N),
		.o_we_n(O_FLASH_WE_N),
		.o_oe_n(O_FLASH_OE_N),
		.o_addr(O_FLASH_ADDR),
		.o_dq(O_FLASH_DQ),
		.o_dq_oe_n(O_FLASH_DQ_OE_N),
		.i_dq(I_FLASH_DQ)
	);

endmodule

// ==== sim/fpes_ctrl_assertions.sv ====
`timescale 1ns/100ps
// ------------------------------------------------------------
// Flash strobe checks.
// ------------------------------------------------------------
module fpes_ctrl_assertions (
	input wire logic I_CLK_SYS,
	input wire logic I_RESET_N,
	input wire logic O_FLASH_CE_N,
	input wire logic O_FLASH_WE_N,
	input wire logic O_FLASH_OE_N,
	input wire logic [19:0] O_FLASH_ADDR,
	input wire logic [15:0] O_FLASH_DQ,
	input wire logic [15:0] O_FLASH_DQ_OE_N
);
	default clocking @(posedge I_CLK_SYS); endclocking
	default disable iff (!I_RESET_N);
	we_pulse_a: assert property ($fell(O_FLASH_WE_N) |-> !O_FLASH_WE_N [*4] ##1 O_FLASH_WE_N)
		else $error("write pulse length wrong");
	ce_setup_a: assert property ($fell(O_FLASH_WE_N) |-> !$past(O_FLASH_CE_N))
		else $error("chip enable not ahead of write");
	ce_hold_a: assert property ($rose(O_FLASH_WE_N) |-> !O_FLASH_CE_N ##1 O_FLASH_CE_N)
		else $error("chip enable hold wrong");
	wr_stable_a: assert property (!O_FLASH_WE_N |-> $stable(O_FLASH_ADDR) && $stable(O_FLASH_DQ))
		else $error("address or data moved in write");
	dq_drive_a: assert property (!O_FLASH_WE_N |-> O_FLASH_DQ_OE_N[7:0] == 8'h00)
		else $error("command byte not driven");
	no_fight_a: assert property (!O_FLASH_OE_N |-> &O_FLASH_DQ_OE_N[14:0])
		else $error("data driven during read");
	rd_stable_a: assert property (!O_FLASH_OE_N && !$fell(O_FLASH_OE_N) |-> $stable(O_FLASH_ADDR))
		else $error("address moved in read");
endmodule
bind fpes_ctrl fpes_ctrl_assertions u_fpes_chk (.I_CLK_SYS, .I_RESET_N, .O_FLASH_CE_N,
	.O_FLASH_WE_N, .O_FLASH_OE_N, .O_FLASH_ADDR, .O_FLASH_DQ, .O_FLASH_DQ_OE_N);

// ==== sim/fpes_flash_model.sv ====
`timescale 1ns/100ps
// ------------------------------------------------------------
// Behavioural flash device.
// ------------------------------------------------------------
module fpes_flash_model #(
	parameter int T_PROG = 40,
	parameter int T_ERASE = 150
) (
	// Flash pins
	input wire logic i_ce_n,
	input wire logic i_we_n,
	input wire logic i_oe_n,
	input wire logic i_byte_n,
	input wire logic [19:0] i_addr,
	input wire logic [15:0] i_dq,
	output logic [15:0] o_dq,
	output logic o_ready_busy_n
);
	logic [15:0] mem [256];
	logic [15:0] q = 0, pd;
	logic [19:0] la;
	logic [7:0] d;
	logic bsy = 0, prg = 0, ers = 0, chp = 0, sus = 0, srq = 0, tmo = 0, t1 = 0, t2 = 0, ep = 0, p7;
	int st = 0, left;
	initial foreach (mem[i]) mem[i] = 16'hffff;
	assign o_ready_busy_n = bsy ? 1'b0 : 1'bz;
	assign o_dq = i_oe_n || i_ce_n ? ~q : q;
	always @(negedge i_we_n or negedge i_ce_n) if (!i_we_n && !i_ce_n) la = i_addr;
	always @(posedge i_we_n or posedge i_ce_n) if (i_we_n != i_ce_n)
	begin
		d = i_dq[7:0];
		if (tmo && d == 8'hf0)
			{tmo, bsy, prg, ers, sus} = 5'h00;
		else if (bsy || tmo)
			srq = d == 8'hb0 && ers && !chp && !prg;
		else if (st == 3)
		begin
			pd = i_byte_n ? i_dq : i_dq[15] ? {d, 8'hff} : {8'hff, d};
			tmo = |(pd & ~mem[la[7:0]]);
			mem[la[7:0]] &= pd;
			{bsy, prg, p7} = {2'b11, d[7]};
			left = T_PROG;
			st = 0;
		end
		else if (st == 2 && ep && (d == 8'h10 || d == 8'h30 || d == 8'h50))
		begin
			if (d == 8'h10 || (d == 8'h30 ? la[19:11] : {4'h0, la[19:15]}) == 9'h000)
				foreach (mem[i]) mem[i] = 16'hffff;
			{bsy, ers, chp, ep} = {2'b11, d == 8'h10, 1'b0};
			left = T_ERASE;
			st = 0;
		end
		else if (sus && d == 8'h30 && st == 0)
		begin
			{sus, bsy} = 2'b01;
			left = T_ERASE;
		end
		else if (st == 0 && d == 8'haa && la[10:0] == 11'h555)
			st = 1;
		else if (st == 1 && d == 8'h55 && la[10:0] == 11'h2aa)
			st = 2;
		else if (st == 2 && !ep && d == 8'ha0)
			st = 3;
		else if (st == 2 && !ep && !sus && d == 8'h80)
		begin
			ep = 1;
			st = 0;
		end
		else
		begin
			ep = 0;
			st = 0;
		end
	end
	always #20
	begin
		if (bsy && !tmo)
			left = left - 1;
		if (srq)
			{srq, bsy, sus} = 3'b001;
		else if (bsy && !tmo && left == 0)
			{bsy, prg, ers, chp} = prg ? {2'b00, ers, chp} : 4'h0;
	end
	always @(negedge i_oe_n or negedge i_ce_n) if (!i_oe_n && !i_ce_n)
	begin
		t1 = ~t1;
		t2 ^= ers;
		pd = mem[i_addr[7:0]];
		if (bsy || tmo || sus)
			q = {8'h00, prg ? ~p7 : !bsy, bsy & t1, tmo, 1'b0, ers, t2, 2'b00};
		else
			q = i_byte_n ? pd : {8'h00, i_dq[15] ? pd[15:8] : pd[7:0]};
	end
endmodule

// ==== sim/fpes_ctrl_tb.sv ====
`timescale 1ns/100ps
// ------------------------------------------------------------
// Self-checking bench.
// ------------------------------------------------------------
module fpes_ctrl_tb;
	logic I_CLK_SYS = 0, I_RESET_N = 0;
	logic [7:0] I_AXI_AWADDR = 0, I_AXI_ARADDR = 0;
	logic [31:0] I_AXI_WDATA = 0, O_AXI_RDATA, s;
	logic I_AXI_AWVALID = 0, I_AXI_WVALID = 0, I_AXI_BREADY = 0, I_AXI_ARVALID = 0;
	logic I_AXI_RREADY = 0, O_AXI_AWREADY, O_AXI_WREADY, O_AXI_BVALID, O_AXI_ARREADY, O_AXI_RVALID;
	logic [1:0] O_AXI_BRESP, O_AXI_RRESP, r;
	logic O_FLASH_CE_N, O_FLASH_WE_N, O_FLASH_OE_N, O_FLASH_BYTE_N;
	logic [19:0] O_FLASH_ADDR;
	logic [15:0] O_FLASH_DQ, O_FLASH_DQ_OE_N, m_dq;
	wire [15:0] I_FLASH_DQ = (O_FLASH_DQ & ~O_FLASH_DQ_OE_N) | (m_dq & O_FLASH_DQ_OE_N);
	wire I_FLASH_READY_BUSY_N;
	int miscompares = 0, checked = 0;
	logic rbl = 0;
	pullup (I_FLASH_READY_BUSY_N);
	always #10 I_CLK_SYS = ~I_CLK_SYS;
	fpes_ctrl #(.SUSPEND_WAIT_CYC(10)) DUT (.I_CLK_SYS, .I_RESET_N, .I_AXI_AWADDR, .I_AXI_AWVALID,
		.O_AXI_AWREADY, .I_AXI_WDATA, .I_AXI_WSTRB(4'hf), .I_AXI_WVALID, .O_AXI_WREADY,
		.O_AXI_BRESP, .O_AXI_BVALID, .I_AXI_BREADY, .I_AXI_ARADDR, .I_AXI_ARVALID, .O_AXI_ARREADY,
		.O_AXI_RDATA, .O_AXI_RRESP, .O_AXI_RVALID, .I_AXI_RREADY, .O_FLASH_CE_N, .O_FLASH_WE_N,
		.O_FLASH_OE_N, .O_FLASH_BYTE_N, .O_FLASH_ADDR, .O_FLASH_DQ, .O_FLASH_DQ_OE_N, .I_FLASH_DQ,
		.I_FLASH_READY_BUSY_N);
	fpes_flash_model u_flash (.i_ce_n(O_FLASH_CE_N), .i_we_n(O_FLASH_WE_N), .i_oe_n(O_FLASH_OE_N),
		.i_byte_n(O_FLASH_BYTE_N), .i_addr(O_FLASH_ADDR), .i_dq(I_FLASH_DQ), .o_dq(m_dq),
		.o_ready_busy_n(I_FLASH_READY_BUSY_N));
	task automatic chk(input string n, input logic [31:0] v, input logic [31:0] e);
		checked++;
		if (v !== e)
		begin
			miscompares++;
			$display("Error %s expected %h seen %h", n, e, v);
		end
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge I_CLK_SYS);
		I_AXI_AWADDR <= a;
		I_AXI_WDATA <= d;
		I_AXI_AWVALID <= 1;
		I_AXI_WVALID <= 1;
		I_AXI_BREADY <= 1;
		do
		begin
			@(posedge I_CLK_SYS);
			if (O_AXI_AWREADY) I_AXI_AWVALID <= 0;
			if (O_AXI_WREADY) I_AXI_WVALID <= 0;
		end
		while (I_AXI_AWVALID || I_AXI_WVALID);
		do @(posedge I_CLK_SYS); while (!O_AXI_BVALID);
		r = O_AXI_BRESP;
		I_AXI_BREADY <= 0;
	endtask
	task automatic axi_rd(input logic [7:0] a);
		@(posedge I_CLK_SYS);
		I_AXI_ARADDR <= a;
		I_AXI_ARVALID <= 1;
		I_AXI_RREADY <= 1;
		do @(posedge I_CLK_SYS); while (!O_AXI_ARREADY);
		I_AXI_ARVALID <= 0;
		do @(posedge I_CLK_SYS); while (!O_AXI_RVALID);
		s = O_AXI_RDATA;
		r = O_AXI_RRESP;
		I_AXI_RREADY <= 0;
	endtask
	task automatic op(input logic [2:0] o, input logic [20:0] a, input logic [15:0] w, input logic b);
		axi_wr(8'h04, {11'h000, a});
		axi_wr(8'h08, {16'h0000, w});
		axi_wr(8'h00, {23'h000000, b, 5'h00, o});
		rbl = 0;
		do
		begin
			axi_rd(8'h0c);
			rbl |= !s[2];
		end
		while (s[3] !== 1'b1 || s[0] !== 1'b0);
	endtask
	task automatic t_regs();
		axi_rd(8'h0c);
		chk("status", s, 32'h4);
		axi_rd(8'h40);
		chk("rresp", r, 2'h2);
		axi_wr(8'h40, 32'h0);
		chk("bresp", r, 2'h2);
	endtask
	task automatic t_prog();
		op(3'h1, 21'h10, 16'h1234, 0);
		axi_rd(8'h10);
		chk("pdata", s, 32'h1234);
		op(3'h1, 21'h10, 16'h00ff, 0);
		chk("tmo", s[1], 1);
		op(3'h0, 21'h10, 16'h0, 0);
		axi_rd(8'h10);
		chk("rdata", s, 32'h34);
		op(3'h1, 21'h10, 16'h0030, 0);
		chk("tmo0", s[1], 0);
	endtask
	task automatic t_erase();
		for (int i = 2; i < 5; i++)
		begin
			op(3'h1, 21'h10, 16'h0f0f, 0);
			op(i[2:0], 21'h0, 16'h0, 0);
			chk("rbusy", rbl, 1);
			op(3'h0, 21'h10, 16'h0, 0);
			axi_rd(8'h10);
			chk("erase", s, 32'hffff);
		end
	endtask
	task automatic t_misc();
		op(3'h1, 21'h10, 16'h8001, 0);
		for (int i = 5; i < 8; i++)
			op(i[2:0], 21'h0, 16'h0, 0);
		op(3'h0, 21'h10, 16'h0, 0);
		axi_rd(8'h10);
		chk("kept", s, 32'h8001);
	endtask
	task automatic t_byte();
		op(3'h3, 21'h0, 16'h0, 0);
		op(3'h1, 21'h21, 16'h005a, 1);
		op(3'h0, 21'h10, 16'h0, 0);
		axi_rd(8'h10);
		chk("word", s, 32'h5aff);
		op(3'h0, 21'h21, 16'h0, 1);
		axi_rd(8'h10);
		chk("byte", s[7:0], 8'h5a);
	endtask
	task automatic close_out();
		$display("miscompares %0d checked %0d", miscompares, checked);
		if (miscompares == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial
	begin
		repeat (16) @(posedge I_CLK_SYS);
		I_RESET_N <= 1;
		repeat (2) @(posedge I_CLK_SYS);
		t_regs();
		t_prog();
		t_erase();
		t_misc();
		t_byte();
		close_out();
	end
	initial
	begin
		#1500000;
		miscompares++;
		close_out();
	end
endmodule
